// >>> rtl/sso_status_output.sv
// Status output logic: zero speed, brake interlock, warnings and alarm code on three shared pins.
// Assumes status inputs and motor speed synchronous to clock; AXI4-Lite master keeps the protocol.
// Operation
// R1 - Zero-speed flag set when speed magnitude is at or below level, default 50.
// R2 - Zero-speed level comes from a writable threshold setting.
// R3 - Hysteresis of 20 r/min; flag holds until magnitude reaches level plus 20.
// R4 - Default: flag clears at 70 r/min either direction, sets again at 50.
// R5 - Brake interlock drops when servo is off or any alarm is present.
// R6 - When enabled, brake interlock replaces the zero-speed flag on its pin.
// R7 - Warning outputs appear only on a selected pin, replacing its old signal.
// R8 - Warning output is on whenever any warning is active; the code holds it off until the power-on window ends.
// R9 - Without warning, warning output is inactive within 1.5 s of power-on.
// R10 - Battery warning on for cable-break or battery-low warning.
// R11 - Without battery warning, its output is inactive within 1.5 s of power-on.
// R12 - With alarm code enabled and alarm active, shared pins carry the code.
// R13 - Code 000 for fatal internal faults; first shared pin is the MSB.
// R14 - Codes: overvoltage 001, undervoltage 010, main circuit 100, position faults 101.
// R15 - Ready is on when servo is on and the amplifier is ready.
// R16 - Brake interlock on only while servo is on and no alarm.
`timescale 1ns/1ps
module sso_status_output
   import sso_pkg::*;
#(
   parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [15:0] motorSpeed,
   input wire sso_status_t status,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic [2:0] sharedPin,
   output logic irq
);
   sso_phase_t phase;
   logic [31:0] startCnt;
   logic [31:0] ctrl;
   logic [IRQ_W-1:0] irqStat;
   logic [IRQ_W-1:0] irqEn;
   logic [IRQ_W-1:0] lvlPrev;
   logic zeroSpeed;
   logic next_zeroSpeed;
   logic [15:0] speedMag;
   logic [15:0] threshold;
   logic [16:0] offLevel;
   logic running;
   logic readyFlag;
   logic brakeInterlock;
   logic warningFlag;
   logic batteryWarningFlag;
   logic [2:0] alarmCode;
   logic [2:0] next_sharedPin;
   logic [1:0] warnSel;
   logic [1:0] battSel;
   logic codeOut;
   logic [IRQ_W-1:0] lvlNow;
   logic [IRQ_W-1:0] clrMask;
   logic awHeld;
   logic wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic doWrite;
   logic [ADDR_W-1:0] wrWord;
   logic [ADDR_W-1:0] rdWord;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Power-on settle window: warning pins held off until it ends
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         phase <= PH_BOOT;
         startCnt <= '0;
      end else begin
         case (phase)
            PH_BOOT: begin
               if (startCnt >= 32'(STARTUP_CYCLES - 1)) begin
                  phase <= PH_RUN;
               end else begin
                  startCnt <= startCnt + 32'h0000_0001;
               end
            end
            PH_RUN: phase <= PH_RUN;
            default: phase <= PH_BOOT;
         endcase
      end
   end
   assign running = (phase == PH_RUN);

   assign threshold = ctrl[15:0]; // R2
   assign speedMag = motorSpeed[15] ? (~motorSpeed + 16'h0001) : motorSpeed;
   // Widened so a large threshold cannot wrap the release level
   assign offLevel = {1'b0, threshold} + {1'b0, ZS_HYST}; // R3

   always_comb begin
      next_zeroSpeed = zeroSpeed;
      if (zeroSpeed) begin
         if ({1'b0, speedMag} >= offLevel) begin
            next_zeroSpeed = 1'b0; // R4
         end
      end else if (speedMag <= threshold) begin
         next_zeroSpeed = 1'b1; // R1
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         zeroSpeed <= 1'b0;
      end else begin
         zeroSpeed <= next_zeroSpeed;
      end
   end

   assign readyFlag = status.servoOn & status.ampReady; // R15
   assign brakeInterlock = status.servoOn & ~status.alarmActive; // R5 R16
   assign warningFlag = running & status.warningActive; // R8 R9
   assign batteryWarningFlag = running & (status.batteryCableBreakWarning | status.batteryLowWarning); // R10 R11

   always_comb begin
      case (status.alarmCause)
         CAUSE_FATAL: alarmCode = ACD_FATAL; // R13
         CAUSE_OVERVOLT: alarmCode = ACD_OVERVOLT; // R14
         CAUSE_UNDERVOLT: alarmCode = ACD_UNDERVOLT;
         CAUSE_OVERLOAD: alarmCode = ACD_OVERLOAD;
         CAUSE_MAIN: alarmCode = ACD_MAIN;
         CAUSE_POSERR: alarmCode = ACD_POSERR;
         CAUSE_ENCODER: alarmCode = ACD_ENCODER;
         default: alarmCode = ACD_FATAL;
      endcase
   end

   assign warnSel = ctrl[CTRL_WSEL_LSB +: 2];
   assign battSel = ctrl[CTRL_BSEL_LSB +: 2];
   assign codeOut = ctrl[CTRL_ACD_BIT] & status.alarmActive;

   always_comb begin
      next_sharedPin[PIN_READY] = readyFlag;
      next_sharedPin[PIN_ZS] = ctrl[CTRL_BRK_BIT] ? brakeInterlock : zeroSpeed; // R6
      next_sharedPin[PIN_POS] = ctrl[CTRL_SPD_BIT] ? status.speedReached : status.inPosition;
      // Battery wins if both warnings pick the same pin
      if (warnSel != SEL_NONE) begin
         next_sharedPin[warnSel - 2'h1] = warningFlag; // R7
      end
      if (battSel != SEL_NONE) begin
         next_sharedPin[battSel - 2'h1] = batteryWarningFlag; // R7
      end
      if (codeOut) begin
         next_sharedPin[PIN_READY] = alarmCode[2]; // R12
         next_sharedPin[PIN_ZS] = alarmCode[1];
         next_sharedPin[PIN_POS] = alarmCode[0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sharedPin <= '0;
      end else begin
         sharedPin <= next_sharedPin;
      end
   end

   // Interrupts: rising edges of zero speed, alarm, warning and battery warning, set wins over clear
   assign lvlNow = {batteryWarningFlag, warningFlag, status.alarmActive, zeroSpeed};
   assign clrMask = (doWrite && wrWord == ADDR_IRQ_CLR && wStrb[0]) ? wData[IRQ_W-1:0] : '0;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         lvlPrev <= '0;
         irqStat <= '0;
      end else begin
         lvlPrev <= lvlNow;
         irqStat <= (irqStat & ~clrMask) | (lvlNow & ~lvlPrev);
      end
   end
   assign irq = |(irqStat & irqEn);

   // AXI4-Lite write: address and data taken in either order
   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
   assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
   assign wrWord = {awAddr[ADDR_W-1:2], 2'b00};

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= '0;
         wData <= '0;
         wStrb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wrWord)
               ADDR_CTRL, ADDR_STAT, ADDR_IRQ_STAT, ADDR_IRQ_EN, ADDR_IRQ_CLR: s_axi_bresp <= RESP_OKAY;
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ctrl <= CTRL_RESET;
         irqEn <= '0;
      end else if (doWrite) begin
         if (wrWord == ADDR_CTRL) begin
            ctrl <= merge(ctrl, wData, wStrb);
         end
         if (wrWord == ADDR_IRQ_EN && wStrb[0]) begin
            irqEn <= wData[IRQ_W-1:0];
         end
      end
   end

   // AXI4-Lite read: one outstanding, data captured at address handshake
   assign s_axi_arready = ~s_axi_rvalid;
   assign rdWord = {s_axi_araddr[ADDR_W-1:2], 2'b00};

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
         case (rdWord)
            ADDR_CTRL: s_axi_rdata <= ctrl;
            ADDR_STAT: begin
               s_axi_rdata[ST_ZS] <= zeroSpeed;
               s_axi_rdata[ST_BRK] <= brakeInterlock;
               s_axi_rdata[ST_WNG] <= warningFlag;
               s_axi_rdata[ST_BAT] <= batteryWarningFlag;
               s_axi_rdata[ST_ALM] <= status.alarmActive;
               s_axi_rdata[ST_RDY] <= readyFlag;
               s_axi_rdata[ST_RUN] <= running;
               s_axi_rdata[ST_CODE_LSB +: 3] <= alarmCode;
            end
            ADDR_IRQ_STAT: s_axi_rdata[IRQ_W-1:0] <= irqStat;
            ADDR_IRQ_EN: s_axi_rdata[IRQ_W-1:0] <= irqEn;
            ADDR_IRQ_CLR: s_axi_rdata <= '0;
            default: s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   zs_set_a: assert property ((speedMag <= threshold) |=> zeroSpeed) // R1
      else $error("zero speed not set at or below level");
   zs_hold_a: assert property ((zeroSpeed && ({1'b0, speedMag} < offLevel)) |=> zeroSpeed) // R3
      else $error("zero speed dropped inside hysteresis");
   zs_off_a: assert property (({1'b0, speedMag} >= offLevel) |=> !zeroSpeed) // R4
      else $error("zero speed held above release level");
   brk_off_a: assert property ((ctrl[CTRL_BRK_BIT] && !codeOut && warnSel != 2'h2 && battSel != 2'h2
      && (!status.servoOn || status.alarmActive)) |=> !sharedPin[PIN_ZS]) // R5
      else $error("brake interlock on while off or alarmed");
   brk_on_a: assert property ((ctrl[CTRL_BRK_BIT] && warnSel != 2'h2 && battSel != 2'h2
      && status.servoOn && !status.alarmActive) |=> sharedPin[PIN_ZS]) // R16
      else $error("brake interlock off while servo on");
   acd_pins_a: assert property (codeOut |=> (sharedPin == {$past(alarmCode[0]), $past(alarmCode[1]),
      $past(alarmCode[2])})) // R12
      else $error("alarm code not on shared pins");
   boot_quiet_a: assert property ((!running && warnSel != SEL_NONE && !codeOut)
      |=> !sharedPin[$past(warnSel) - 2'h1]) // R9
      else $error("warning pin on during power-on window");
   bat_quiet_a: assert property ((!running && battSel != SEL_NONE && !codeOut)
      |=> !sharedPin[$past(battSel) - 2'h1]) // R11
      else $error("battery warning pin on during power-on window");
   warn_pin_a: assert property ((warnSel != SEL_NONE && battSel != warnSel && !codeOut && running
      && status.warningActive) |=> sharedPin[$past(warnSel) - 2'h1]) // R8
      else $error("warning not on its selected pin");
   ready_pin_a: assert property ((!codeOut && warnSel != 2'h1 && battSel != 2'h1 && status.servoOn
      && status.ampReady) |=> sharedPin[PIN_READY]) // R15
      else $error("ready pin low while ready");
endmodule

// >>> pkg/sso_pkg.sv
// Constants, field layout and carrier types of the servo status output block.
// Assumes a 20 MHz core clock and 32-bit AXI4-Lite register access.
package sso_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam real STARTUP_S = 1.5;
   // Longest time, so the cycle count rounds down
   localparam int unsigned STARTUP_CYC = $rtoi(STARTUP_S * CLK_HZ);
   localparam logic [15:0] ZS_DEFAULT = 16'h0032;
   localparam logic [15:0] ZS_HYST = 16'h0014;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
   localparam logic [31:0] CTRL_RESET = {16'h0000, ZS_DEFAULT};
   localparam int CTRL_ACD_BIT = 16;
   localparam int CTRL_BRK_BIT = 17;
   localparam int CTRL_SPD_BIT = 18;
   localparam int CTRL_WSEL_LSB = 20;
   localparam int CTRL_BSEL_LSB = 22;
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam int ST_ZS = 0;
   localparam int ST_BRK = 1;
   localparam int ST_WNG = 2;
   localparam int ST_BAT = 3;
   localparam int ST_ALM = 4;
   localparam int ST_RDY = 5;
   localparam int ST_RUN = 6;
   localparam int ST_CODE_LSB = 8;
   localparam int IRQ_W = 4;
   localparam int PIN_READY = 0;
   localparam int PIN_ZS = 1;
   localparam int PIN_POS = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [2:0] ACD_FATAL = 3'h0;
   localparam logic [2:0] ACD_OVERVOLT = 3'h1;
   localparam logic [2:0] ACD_UNDERVOLT = 3'h2;
   localparam logic [2:0] ACD_OVERLOAD = 3'h3;
   localparam logic [2:0] ACD_MAIN = 3'h4;
   localparam logic [2:0] ACD_POSERR = 3'h5;
   localparam logic [2:0] ACD_ENCODER = 3'h6;
   typedef enum logic [2:0] {
      CAUSE_FATAL = 3'h0, CAUSE_OVERVOLT = 3'h1, CAUSE_UNDERVOLT = 3'h2, CAUSE_OVERLOAD = 3'h3,
      CAUSE_MAIN = 3'h4, CAUSE_POSERR = 3'h5, CAUSE_ENCODER = 3'h6
   } sso_cause_t;
   typedef enum logic [1:0] {PH_BOOT = 2'b01, PH_RUN = 2'b10} sso_phase_t;
   typedef struct packed {
      logic servoOn;
      logic ampReady;
      logic inPosition;
      logic speedReached;
      logic alarmActive;
      sso_cause_t alarmCause;
      logic warningActive;
      logic batteryCableBreakWarning;
      logic batteryLowWarning;
   } sso_status_t;
endpackage

// >>> sim/sso_host_model.sv
// Host controller model that latches the discrete status pins and the interrupt.
// Assumes the pins are registered levels in the clock domain of the block.
`timescale 1ns/1ps
module sso_host_model (
   input wire logic clock,
   input wire logic [2:0] sharedPin,
   input wire logic irq,
   output logic [2:0] seenPin,
   output logic seenIrq
);
   // Levels only, so one sample a clock loses nothing
   always_ff @(posedge clock) begin
      seenPin <= sharedPin;
      seenIrq <= irq;
   end
endmodule

// >>> sim/sso_status_output_test.sv
// Self-checking bench for the servo status output block over AXI4-Lite and its pins.
// Assumes a shortened startup window and a host model sampling the pins.
`timescale 1ns/1ps
module sso_status_output_test;
   import sso_pkg::*;
   localparam int unsigned BOOT = 16;
   logic clock = 0;
   logic rst_b = 0;
   logic [15:0] motorSpeed = 16'h0000;
   sso_status_t st = '{warningActive: 1'b1, batteryLowWarning: 1'b1, alarmCause: CAUSE_FATAL, default: 1'b0};
   logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
   logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
   logic [31:0] wData = 32'h0000_0000;
   logic [3:0] wStrb = 4'h0;
   logic awReady, wReady, bValid, arReady, rValid, irq, seenIrq;
   logic [1:0] bResp, rResp, r;
   logic [31:0] rData, d;
   logic [2:0] sharedPin, seenPin;
   int error_cnt = 0;
   int checks = 0;
   logic [2:0] alarmCodes [7] = '{ACD_FATAL, ACD_OVERVOLT, ACD_UNDERVOLT, ACD_OVERLOAD, ACD_MAIN, ACD_POSERR,
      ACD_ENCODER};

   sso_status_output #(.STARTUP_CYCLES(BOOT)) sso_status_output_i (.clock(clock), .rst_b(rst_b),
      .motorSpeed(motorSpeed), .status(st), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
      .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .sharedPin(sharedPin), .irq(irq));
   sso_host_model sso_host_model_i (.clock(clock), .sharedPin(sharedPin), .irq(irq), .seenPin(seenPin),
      .seenIrq(seenIrq));

   initial begin
      forever #25 clock = ~clock;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   // Ready is judged at the falling edge, so the handshake edge itself is never raced
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic pa, pw, ta, tw;
      int n;
      pa = 1;
      pw = 1;
      n = 0;
      @(posedge clock);
      awValid <= 1;
      awAddr <= a;
      wValid <= 1;
      wData <= v;
      wStrb <= 4'hf;
      bReady <= 1;
      while ((pa || pw) && n < 50) begin
         @(negedge clock);
         n++;
         ta = pa && awReady;
         tw = pw && wReady;
         @(posedge clock);
         if (ta) begin
            awValid <= 0;
            pa = 0;
         end
         if (tw) begin
            wValid <= 0;
            pw = 0;
         end
      end
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (bValid !== 1'b1 && n < 50);
      resp = bResp;
      chk({31'h0, bValid}, 32'h0000_0001, "write response");
      @(posedge clock);
      bReady <= 0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clock);
      arValid <= 1;
      arAddr <= a;
      rReady <= 1;
      do begin
         @(negedge clock);
         n++;
      end while (arReady !== 1'b1 && n < 50);
      @(posedge clock);
      arValid <= 0;
      do begin
         @(negedge clock);
         n++;
      end while (rValid !== 1'b1 && n < 100);
      v = rData;
      resp = rResp;
      chk({31'h0, rValid}, 32'h0000_0001, "read response");
      @(posedge clock);
      rReady <= 0;
   endtask

   task automatic pin(input int b, input logic e, input string m);
      repeat (4) @(posedge clock);
      chk({31'h0, seenPin[b]}, {31'h0, e}, m);
   endtask

   task automatic sweep(input int sp[7], input logic [6:0] ex);
      for (int i = 0; i < 7; i++) begin
         motorSpeed <= 16'(sp[i]);
         pin(PIN_ZS, ex[i], "zero speed flag");
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1;
      rd(ADDR_CTRL, d, r);
      chk(d, CTRL_RESET, "threshold default");
      wr(ADDR_CTRL, 32'h00D0_0032, r);
      rd(ADDR_STAT, d, r);
      chk({30'h0, d[3:2]}, 32'h0000_0000, "warnings during startup");
      chk({30'h0, seenPin[PIN_POS], seenPin[PIN_READY]}, 32'h0000_0000, "warning pins in startup");
      repeat (BOOT) @(posedge clock);
      rd(ADDR_STAT, d, r);
      chk({29'h0, d[6], d[3:2]}, 32'h0000_0007, "warnings after startup");
      chk({30'h0, seenPin[PIN_POS], seenPin[PIN_READY]}, 32'h0000_0003, "warning pins after startup");
      $display("test startup done");
      st.warningActive <= 0;
      st.batteryLowWarning <= 0;
      sweep('{69, 70, 51, 50, -69, -70, -50}, 7'h59);
      wr(ADDR_CTRL, 32'h0000_0064, r);
      sweep('{120, 101, 100, 119, 120, -100, -120}, 7'h2C);
      $display("test zero speed done");
      wr(ADDR_CTRL, 32'h0006_0064, r);
      st.servoOn <= 1;
      st.ampReady <= 1;
      st.speedReached <= 1;
      pin(PIN_ZS, 1, "brake released");
      chk({31'h0, seenPin[PIN_READY]}, 32'h0000_0001, "ready on");
      chk({31'h0, seenPin[PIN_POS]}, 32'h0000_0001, "speed reached shown");
      st.alarmActive <= 1;
      pin(PIN_ZS, 0, "brake on alarm");
      st.alarmActive <= 0;
      st.servoOn <= 0;
      pin(PIN_ZS, 0, "brake on servo off");
      chk({31'h0, seenPin[PIN_READY]}, 32'h0000_0000, "ready off");
      $display("test brake done");
      wr(ADDR_CTRL, 32'h00D0_0064, r);
      st.servoOn <= 1;
      st.inPosition <= 1;
      pin(PIN_READY, 0, "ready replaced");
      chk({31'h0, seenPin[PIN_POS]}, 32'h0000_0000, "in position replaced");
      st.warningActive <= 1;
      pin(PIN_READY, 1, "warning shown");
      st.batteryCableBreakWarning <= 1;
      pin(PIN_POS, 1, "cable break shown");
      st.batteryCableBreakWarning <= 0;
      st.batteryLowWarning <= 1;
      pin(PIN_POS, 1, "battery low shown");
      $display("test warning pins done");
      wr(ADDR_CTRL, 32'h00D1_0064, r);
      st.alarmActive <= 1;
      for (int c = 0; c < 7; c++) begin
         st.alarmCause <= sso_cause_t'(c[2:0]);
         repeat (4) @(posedge clock);
         chk({29'h0, seenPin}, {29'h0, alarmCodes[c][0], alarmCodes[c][1], alarmCodes[c][2]}, "alarm code");
      end
      st.alarmActive <= 0;
      pin(PIN_READY, 1, "ordinary signals back");
      $display("test alarm code done");
      wr(ADDR_IRQ_CLR, 32'h0000_000F, r);
      wr(ADDR_IRQ_EN, 32'h0000_0001, r);
      repeat (3) @(posedge clock);
      chk({31'h0, seenIrq}, 32'h0000_0000, "irq idle");
      motorSpeed <= 16'h0000;
      pin(PIN_ZS, 1, "zero speed event");
      chk({31'h0, seenIrq}, 32'h0000_0001, "irq raised");
      wr(ADDR_IRQ_CLR, 32'h0000_0001, r);
      repeat (3) @(posedge clock);
      chk({31'h0, seenIrq}, 32'h0000_0000, "irq cleared");
      wr(ADDR_IRQ_EN, 32'h0000_0000, r);
      motorSpeed <= 16'h00C8;
      pin(PIN_ZS, 0, "speed up");
      motorSpeed <= 16'h0000;
      pin(PIN_ZS, 1, "masked event");
      chk({31'h0, seenIrq}, 32'h0000_0000, "irq masked");
      rd(ADDR_IRQ_STAT, d, r);
      chk({31'h0, d[0]}, 32'h0000_0001, "sticky event");
      rd(8'h20, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read response");
      chk(d, 32'h0000_0000, "unmapped read data");
      wr(8'h20, 32'h0000_0001, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
      $display("test bus and irq done");
      report_and_stop();
   end
endmodule
